// file: window_check_if.sv
// Purpose: carries window selection and count between top and window decoder
// Assumes: single clock domain
// Notes:   purely combinational signals
`timescale 1ns/1ps
`default_nettype none
interface window_check_if;
    logic [2:0] windowSel;
    logic [4:0] windowCount;
    logic       windowOpen;
    modport top (output windowSel, output windowCount, input windowOpen);
    modport dec (input windowSel, input windowCount, output windowOpen);
endinterface
`default_nettype wire

// file: window_decode.sv
// Purpose: decide whether the watchdog window is open
// Assumes: count is the five top bits of the counting chain
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module window_decode (
    window_check_if.dec wc
);
    import wwdt_pkg::*;
    logic [4:0] threshold;
    // ------------------------------------------------------------
    // threshold decode
    // ------------------------------------------------------------
    // threshold compare
    always_comb begin
        threshold = 5'(THR_BASE - 5'(wc.windowSel * THR_STEP));
        if (wc.windowSel == WIN_ALWAYS) begin
            wc.windowOpen = 1'b1;
        end else begin
            wc.windowOpen = (wc.windowCount >= threshold);
        end
    end
endmodule // window_decode
`default_nettype wire

// file: wwdt_pkg.sv
// Purpose: shared constants for the windowed watchdog read-out block
// Assumes: 32-bit apb data, 8-bit registers in the low byte
// Notes:   one aligned word per register
`default_nettype none
package wwdt_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL0   = 8'h00;
    localparam logic [7:0] ADDR_CTRL1   = 8'h04;
    localparam logic [7:0] ADDR_PSLOW   = 8'h08;
    localparam logic [7:0] ADDR_PSHIGH  = 8'h0c;
    localparam logic [7:0] ADDR_TIMER   = 8'h10;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h14;
    localparam logic [7:0] ADDR_IRQMASK = 8'h18;
    localparam logic [7:0] ADDR_CLEAR   = 8'h1c;
    // control-one fields
    localparam int CS_LSB  = 4;
    localparam int WIN_LSB = 0;
    // timer read-out fields
    localparam int TMR_LSB   = 3;
    localparam int ARMED_BIT = 2;
    // widths
    localparam int PS_W   = 18;
    localparam int WCNT_W = 5;
    localparam int CHAIN_W = PS_W + WCNT_W;
    // configuration values
    localparam logic [2:0] CFG_UNLOCKED = 3'h7;
    localparam logic [2:0] CS_RESET     = 3'h0;
    localparam logic [2:0] WIN_ALWAYS   = 3'h7;
    localparam logic [4:0] THR_BASE     = 5'h1c;
    localparam logic [4:0] THR_STEP     = 5'h04;
    // interrupt status bits
    localparam int IRQ_VIOL = 0;
    localparam int IRQ_W    = 1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage
`default_nettype wire

// file: wwdt_readout.sv
// Purpose: window select, clock select locking and prescaler read-out of a watchdog
// Assumes: apb slave, clk_sys 100 MHz, synchronous active-low reset
// Notes:   violation is reported as a two-cycle pulse and a sticky status bit
//
// Behaviour
// - window opens when count reaches 11100 minus 00100 per code; 111 always open
// - clock select loads 000 at reset when clock config bits are 111
// - window select loads from window-size config bits at reset
// - clock select read-only unless clock config bits are 111
// - window select read-only unless window config bits are 111
// - low read-out register shows prescaler bits 7..0
// - high read-out register shows prescaler bits 15..8
// - timer read-out bits 1..0 show prescaler bits 17..16
// - prescaler count is 18 bits wide, split over three registers
// - timer read-out bit 2 shows the armed flag
// - timer read-out is read-only and zero after any reset
// - clear while window closed is a violation causing reset
// - clear without arming is a violation; arming is a control-zero read
// - only top five bits of timer read-out decide the window
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wwdt_readout (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [2:0]  clockSourceConfigBits,
    input  wire logic [2:0]  windowSizeConfigBits,
    input  wire logic        windowedMode,
    input  wire logic        countTick,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             violationReset,
    output logic             irq
);
    import wwdt_pkg::*;

    typedef struct packed {
        logic [2:0]           clockSel;
        logic [2:0]           windowSel;
        logic [7:0]           ctrlZero;
        logic [CHAIN_W-1:0]   chain;
        logic                 armed;
        logic                 resetPending;
        logic [IRQ_W-1:0]     irqStat;
        logic [IRQ_W-1:0]     irqMask;
        logic [31:0]          rdata;
        logic                 ready;
        logic                 err;
        logic                 viol;
        logic                 irqOut;
    } state_t;

    state_t stateReg;
    state_t stateNext;
    window_check_if wc ();

    // ------------------------------------------------------------
    // window decoder
    // ------------------------------------------------------------
    window_decode decoder (
        .wc (wc.dec)
    );
    assign wc.windowSel   = stateReg.windowSel;
    assign wc.windowCount = stateReg.chain[CHAIN_W-1 -: WCNT_W];

    logic       access;
    logic       wrEn;
    logic       rdEn;
    logic       clearHit;
    logic       violation;
    logic [7:0] timerByte;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one wait state: pready rises in the second access cycle
    always_comb begin
        stateNext = stateReg;
        access    = psel && penable && !stateReg.ready;
        wrEn      = access && pwrite;
        rdEn      = access && !pwrite;
        clearHit  = wrEn && (paddr == ADDR_CLEAR);
        timerByte = {stateReg.chain[CHAIN_W-1 -: WCNT_W], stateReg.armed,
                     stateReg.chain[PS_W-1 -: 2]};
        violation = clearHit && windowedMode && (!stateReg.armed || !wc.windowOpen);
        stateNext.ready = access;
        stateNext.err   = 1'b0;
        stateNext.viol  = violation;
        stateNext.rdata = stateReg.rdata;
        if (countTick) begin
            stateNext.chain = CHAIN_W'(stateReg.chain + 1'b1);
        end
        // writes to control registers clear the timer as well
        if (clearHit || (wrEn && (paddr == ADDR_CTRL0 || paddr == ADDR_CTRL1))) begin
            stateNext.chain = '0;
            stateNext.armed = 1'b0;
        end
        if (wrEn) begin
            case (paddr)
                ADDR_CTRL0: begin
                    stateNext.ctrlZero = pwdata[7:0];
                end
                ADDR_CTRL1: begin
                    if (clockSourceConfigBits == CFG_UNLOCKED) begin
                        stateNext.clockSel = pwdata[CS_LSB +: 3];
                    end
                    if (windowSizeConfigBits == CFG_UNLOCKED) begin
                        stateNext.windowSel = pwdata[WIN_LSB +: 3];
                    end
                end
                ADDR_IRQMASK: begin
                    stateNext.irqMask = pwdata[IRQ_W-1:0];
                end
                ADDR_IRQSTAT: begin
                    stateNext.irqStat = stateReg.irqStat & ~pwdata[IRQ_W-1:0];
                end
                ADDR_CLEAR: begin
                    stateNext.err = 1'b0;
                end
                ADDR_PSLOW, ADDR_PSHIGH, ADDR_TIMER: begin
                    stateNext.err = 1'b0;
                end
                default: begin
                    stateNext.err = 1'b1;
                end
            endcase
        end
        if (rdEn) begin
            case (paddr)
                ADDR_CTRL0: begin
                    stateNext.rdata = {24'h000000, stateReg.ctrlZero};
                    stateNext.armed = 1'b1;
                end
                ADDR_CTRL1: begin
                    stateNext.rdata = {24'h000000, 1'b0, stateReg.clockSel, 1'b0,
                                       stateReg.windowSel};
                end
                ADDR_PSLOW:   stateNext.rdata = {24'h000000, stateReg.chain[7:0]};
                ADDR_PSHIGH:  stateNext.rdata = {24'h000000, stateReg.chain[15:8]};
                ADDR_TIMER:   stateNext.rdata = {24'h000000, timerByte};
                ADDR_IRQSTAT: stateNext.rdata = {31'h00000000, stateReg.irqStat};
                ADDR_IRQMASK: stateNext.rdata = {31'h00000000, stateReg.irqMask};
                ADDR_CLEAR:   stateNext.rdata = 32'h00000000;
                default: begin
                    stateNext.rdata = 32'h00000000;
                    stateNext.err   = 1'b1;
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (violation) begin
            stateNext.irqStat[IRQ_VIOL] = 1'b1;
            stateNext.resetPending = 1'b1;
        end
        stateNext.irqOut = |(stateNext.irqStat & stateNext.irqMask);
        if (stateReg.resetPending) begin
            stateNext.resetPending = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clock select reset value
    always_ff @(posedge clk_sys) begin
        if (!rstn || stateReg.resetPending) begin
            stateReg.clockSel     <= (clockSourceConfigBits == CFG_UNLOCKED) ? CS_RESET
                                     : clockSourceConfigBits;
            stateReg.windowSel    <= windowSizeConfigBits;
            stateReg.ctrlZero     <= BYTE_ZERO;
            stateReg.chain        <= '0;
            stateReg.armed        <= 1'b0;
            stateReg.resetPending <= 1'b0;
            stateReg.rdata        <= 32'h00000000;
            stateReg.ready        <= 1'b0;
            stateReg.err          <= 1'b0;
            stateReg.viol         <= !rstn ? 1'b0 : 1'b1;
            if (!rstn) begin
                stateReg.irqStat <= '0;
                stateReg.irqMask <= '0;
                stateReg.irqOut  <= 1'b0;
            end else begin
                stateReg.irqStat <= stateReg.irqStat;
                stateReg.irqMask <= stateReg.irqMask;
                stateReg.irqOut  <= stateReg.irqOut;
            end
        end else begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata         = stateReg.rdata;
    assign pready         = stateReg.ready;
    assign pslverr        = stateReg.err;
    assign violationReset = stateReg.viol;
    assign irq            = stateReg.irqOut;
endmodule // wwdt_readout
`default_nettype wire

// file: wwdt_readout_properties.sv
// Purpose: port checks for the watchdog read-out block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached to every instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module wwdt_readout_properties (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        windowedMode,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        violationReset,
    input wire logic        irq
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    property p_answer; s_taken |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_cause; pready |-> $past(psel && penable); endproperty
    a_cause: assert property (p_cause) else $error("ready without access");
    property p_err; pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h1c); endproperty
    a_err: assert property (p_err) else $error("wrong error flag");
    property p_errlone; pslverr |-> pready; endproperty
    a_errlone: assert property (p_errlone) else $error("error without ready");
    // internal reset after a violation may clear the read data
    property p_hold; !pready && !violationReset && !$past(violationReset) |-> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $rose(rstn) |-> prdata == 32'h0 && !irq && !violationReset && !pready;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear");
    property p_viol; !windowedMode [*4] |=> !violationReset; endproperty
    a_viol: assert property (p_viol) else $error("violation outside mode");
    property p_vlen; violationReset [*2] |=> !violationReset; endproperty
    a_vlen: assert property (p_vlen) else $error("violation pulse long");
endmodule // wwdt_readout_properties
bind wwdt_readout wwdt_readout_properties chk_u (.clk_sys, .rstn, .windowedMode, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .violationReset, .irq);
`default_nettype wire

// file: wwdt_readout_test.sv
// Purpose: self-checking bench for the watchdog read-out block
// Assumes: one wait state apb slave, 100 MHz clock
// Notes:   thresholds above zero need at least 2^20 ticks, too long to reach here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module wwdt_readout_test;
    import wwdt_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  clockSourceConfigBits = 3'h7;
    logic [2:0]  windowSizeConfigBits = 3'h5;
    logic        windowedMode = 1'b0;
    logic        countTick = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        violationReset;
    logic        irq;
    logic [31:0] q;
    logic        lastErr;
    logic        vSeen = 1'b0;
    int          bad_count = 0;
    int          tests_run = 0;
    wwdt_readout dut_u (.clk_sys, .rstn, .clockSourceConfigBits, .windowSizeConfigBits,
        .windowedMode, .countTick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .violationReset, .irq);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // latch any violation pulse; it may come before the transfer returns
    always @(posedge clk_sys) begin
        if (violationReset === 1'b1) vSeen <= 1'b1;
    end
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            `CHK(pready, 1'b1)
            complete_run();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, {24'h0, e})
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic wd_clear;
        vSeen = 1'b0;
        wr(ADDR_CLEAR, 8'h00);
    endtask
    task automatic vwait(input logic e);
        repeat (5) @(posedge clk_sys);
        `CHK(vSeen, e)
    endtask
    task automatic do_reset(input logic [2:0] c, input logic [2:0] w);
        rstn <= 1'b0;
        clockSourceConfigBits <= c;
        windowSizeConfigBits <= w;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    initial begin
        do_reset(3'h7, 3'h5);
        rd(ADDR_CTRL1, 8'h05);
        wr(ADDR_TIMER, 8'hff);
        rd(ADDR_TIMER, 8'h00);
        rd(ADDR_PSLOW, 8'h00);
        rd(ADDR_PSHIGH, 8'h00);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(lastErr, 1'b1)
        wr(ADDR_CTRL1, 8'h23);
        rd(ADDR_CTRL1, 8'h25);
        do_reset(3'h1, 3'h7);
        rd(ADDR_CTRL1, 8'h17);
        wr(ADDR_CTRL1, 8'h32);
        rd(ADDR_CTRL1, 8'h12);
        $display("test reset and lock done");
        do_reset(3'h7, 3'h7);
        wd_clear();
        vwait(1'b0);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        countTick <= 1'b1;
        repeat (4660) @(posedge clk_sys);
        countTick <= 1'b0;
        rd(ADDR_PSLOW, 8'h34);
        rd(ADDR_PSHIGH, 8'h12);
        rd(ADDR_TIMER, 8'h04);
        $display("test readout done");
        // use up the arming left by the read above, so the next clear is unarmed
        wd_clear();
        windowedMode <= 1'b1;
        wr(ADDR_IRQMASK, 8'h01);
        wd_clear();
        vwait(1'b1);
        rd(ADDR_IRQSTAT, 8'h01);
        `CHK(irq, 1'b1)
        rd(ADDR_CTRL1, 8'h07);
        rd(ADDR_TIMER, 8'h00);
        wr(ADDR_IRQSTAT, 8'h01);
        rd(ADDR_IRQSTAT, 8'h00);
        `CHK(irq, 1'b0)
        apb(1'b0, ADDR_CTRL0, 32'h0);
        wd_clear();
        vwait(1'b0);
        wr(ADDR_CTRL1, 8'h00);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        wd_clear();
        vwait(1'b1);
        wr(ADDR_IRQMASK, 8'h00);
        rd(ADDR_IRQSTAT, 8'h01);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQMASK, 8'h01);
        rd(ADDR_IRQSTAT, 8'h01);
        `CHK(irq, 1'b1)
        $display("test window done");
        complete_run();
    end
endmodule // wwdt_readout_test
`default_nettype wire
